// ---- src/watchdog_consts.vh ----
// Purpose: constants for the watchdog block
// Assumes: 32-bit AXI4-Lite register bus, 25 MHz system clock
// Notes: all offsets are byte addresses
`ifndef WATCHDOG_CONSTS_VH
`define WATCHDOG_CONSTS_VH
// ****************************************
// Register map
// ****************************************
`define OFS_RESET_CTL 4'h0
`define OFS_CONFIG 4'h4
`define OFS_CMD 4'h8
`define OFS_STATUS 4'hc
// ****************************************
// Reset control register bits
// ****************************************
`define BIT_SWEN 5
`define BIT_TIMEOUT 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
// ****************************************
// Config word fields
// ****************************************
`define CFG_POST_LSB 0
`define CFG_PRE_BIT 4
`define CFG_WINDOW_DIS_BIT 6
`define CFG_FIXEN_BIT 7
`define CFG_RESET 8'hcf
// ****************************************
// Command register bits
// ****************************************
`define CMD_CLEAR 0
`define CMD_SLEEP 1
`define CMD_IDLE 2
`define CMD_WAKE 3
`define CMD_CLKSW 4
// ****************************************
// Timing
// ****************************************
`define SYS_CLOCK_HZ 25000000
`define RC_OSC_HZ 32000
// Last count of the 782-clock tick divider, 25 MHz over 32 kHz rounded up
`define RC_TICK_TOP 11'h30d
`define PRE_SHORT 7'h1f
`define PRE_LONG 7'h7f
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- src/low_power_rc_oscillator_divider.v ----
// Purpose: low-power RC tick source for the watchdog
// Assumes: one system clock; tick is a one-cycle enable
// Notes: runs only while enabled, restarts from zero
`timescale 1ns/1ps
`include "watchdog_consts.vh"
module rc_tick_divider
(
   input wire clock,
   input wire arst_n,
   input wire enable,
   output reg tick
);
   reg [10:0] count_reg;
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         count_reg <= 11'h000;
         tick <= 1'b0;
      end
      else if (!enable)
      begin
         count_reg <= 11'h000;
         tick <= 1'b0;
      end
      else if (count_reg == `RC_TICK_TOP)
      begin
         count_reg <= 11'h000;
         tick <= 1'b1;
      end
      else
      begin
         count_reg <= count_reg + 11'h001;
         tick <= 1'b0;
      end
   end
endmodule

// ---- src/watchdog_timer.v ----
// Contract
// - Counter runs from the RC oscillator, which runs whenever watchdog enabled.
// - Prescaler divides by 32 when select is 0, by 128 when 1.
// - Nominal base timeout is 1 ms or 4 ms at 32 kHz.
// - Four-bit postscale field divides by two to the power of code.
// - Reset, clock switch, sleep entry/exit and clear zero the prescale and postscale counters.
// - Counting continues in sleep/idle; timeout there wakes instead of reset.
// - Fixed enable set keeps watchdog running, software enable ignored.
// - Fixed enable clear: software enable bit 5 gates running; reset clears it.
// - Window disable 1 selects non-window mode, 0 selects window mode.
// - Window mode: clear before final quarter of period (final half at postscale 1:2) causes reset outside sleep/idle.
// - Timeout flag bit 4 sets on timeout and stays until cleared.
//
// Purpose: watchdog timer with AXI4-Lite register access
// Assumes: config word written by software stands for the config fuses
// Notes: reset control register bits 5..2 live at offset 0x0
`timescale 1ns/1ps
`include "watchdog_consts.vh"
module watchdog_timer
(
   input wire clock,
   input wire arst_n,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg watchdog_reset,
   output reg wake_up,
   output reg low_power_rc_oscillator_en
);
   // ****************************************
   // State
   // ****************************************
   reg software_enable_bit_reg;
   reg timeout_flag_reg;
   reg sleep_flag_reg;
   reg idle_flag_reg;
   reg [7:0] config_reg;
   reg saving_reg;
   reg [6:0] pre_reg;
   reg [14:0] post_reg;
   reg [31:0] rdata_next;
   reg [1:0] rresp_next;
   reg [1:0] bresp_next;
   reg [3:0] awaddr_reg;
   reg [31:0] wdata_reg;
   reg have_aw_reg;
   reg have_w_reg;
   wire tick;
   wire [3:0] postscale_select;
   wire prescale_select;
   wire window_disable_config;
   wire fixed_enable_config;
   wire running;
   wire [6:0] pre_top;
   wire [14:0] post_top;
   wire [15:0] post_full;
   wire pre_done;
   wire expire;
   wire in_window;
   wire do_write;
   wire cmd_write;
   wire clear_cmd;
   wire enter_save;
   wire leave_save;
   wire restart;
   assign postscale_select = config_reg[`CFG_POST_LSB +: 4];
   assign prescale_select = config_reg[`CFG_PRE_BIT];
   assign window_disable_config = config_reg[`CFG_WINDOW_DIS_BIT];
   assign fixed_enable_config = config_reg[`CFG_FIXEN_BIT];
   assign running = fixed_enable_config | software_enable_bit_reg;
   // ****************************************
   // Oscillator and scalers
   // ****************************************
   rc_tick_divider osc
   (
      .clock(clock),
      .arst_n(arst_n),
      .enable(running),
      .tick(tick)
   );
   assign pre_top = prescale_select ? `PRE_LONG : `PRE_SHORT;
   assign post_full = (16'h0001 << postscale_select) - 16'h0001;
   assign post_top = post_full[14:0];
   assign pre_done = tick && (pre_reg == pre_top);
   assign expire = running && pre_done && (post_reg == post_top);
   // Final quarter: top two bits of postscaled count (top bit, final half, at 1:2), or of prescale at 1:1
   assign in_window = (postscale_select == 4'h0) ? (pre_reg >= (pre_top - (pre_top >> 2))) : (post_reg >= (post_top - (post_top >> 2)));
   // ****************************************
   // Register writes
   // ****************************************
   assign do_write = have_aw_reg && have_w_reg && !s_axi_bvalid;
   assign cmd_write = do_write && (awaddr_reg == `OFS_CMD);
   assign clear_cmd = cmd_write && wdata_reg[`CMD_CLEAR];
   assign enter_save = cmd_write && (wdata_reg[`CMD_SLEEP] | wdata_reg[`CMD_IDLE]) && !saving_reg;
   assign leave_save = saving_reg && (expire || (cmd_write && wdata_reg[`CMD_WAKE]));
   assign restart = !running || clear_cmd || enter_save || leave_save || (cmd_write && wdata_reg[`CMD_CLKSW]);
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pre_reg <= 7'h00;
         post_reg <= 15'h0000;
      end
      else if (restart || expire)
      begin
         pre_reg <= 7'h00;
         post_reg <= 15'h0000;
      end
      else if (tick)
      begin
         if (pre_done)
         begin
            pre_reg <= 7'h00;
            post_reg <= post_reg + 15'h0001;
         end
         else
            pre_reg <= pre_reg + 7'h01;
      end
   end
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         software_enable_bit_reg <= 1'b0;
         timeout_flag_reg <= 1'b0;
         sleep_flag_reg <= 1'b0;
         idle_flag_reg <= 1'b0;
         config_reg <= `CFG_RESET;
         saving_reg <= 1'b0;
         watchdog_reset <= 1'b0;
         wake_up <= 1'b0;
         low_power_rc_oscillator_en <= 1'b0;
      end
      else
      begin
         low_power_rc_oscillator_en <= running;
         wake_up <= expire && saving_reg;
         // reset pulse on expiry or early clear in window mode, both only outside sleep/idle
         watchdog_reset <= (expire && !saving_reg) || (clear_cmd && running && !window_disable_config && !in_window && !saving_reg);
         if (do_write && awaddr_reg == `OFS_CONFIG && s_axi_wstrb[0])
            config_reg <= wdata_reg[7:0];
         if (do_write && awaddr_reg == `OFS_RESET_CTL && s_axi_wstrb[0])
         begin
            software_enable_bit_reg <= wdata_reg[`BIT_SWEN];
            sleep_flag_reg <= wdata_reg[`BIT_SLEEP];
            idle_flag_reg <= wdata_reg[`BIT_IDLE];
            timeout_flag_reg <= wdata_reg[`BIT_TIMEOUT];
         end
         if (enter_save)
         begin
            saving_reg <= 1'b1;
            sleep_flag_reg <= wdata_reg[`CMD_SLEEP];
            idle_flag_reg <= !wdata_reg[`CMD_SLEEP];
         end
         else if (leave_save)
            saving_reg <= 1'b0;
         if (expire)
            timeout_flag_reg <= 1'b1; // set wins over clear
      end
   end
   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   always @*
   begin
      rresp_next = `RESP_OKAY;
      rdata_next = 32'h00000000;
      case (s_axi_araddr)
         `OFS_RESET_CTL:
         begin
            rdata_next[`BIT_SWEN] = software_enable_bit_reg;
            rdata_next[`BIT_TIMEOUT] = timeout_flag_reg;
            rdata_next[`BIT_SLEEP] = sleep_flag_reg;
            rdata_next[`BIT_IDLE] = idle_flag_reg;
         end
         `OFS_CONFIG: rdata_next[7:0] = config_reg;
         `OFS_CMD: rdata_next = 32'h00000000;
         `OFS_STATUS: rdata_next = {1'b0, post_reg, 1'b0, pre_reg, 7'h00, running};
         default: rresp_next = `RESP_SLVERR;
      endcase
      case (awaddr_reg)
         `OFS_RESET_CTL, `OFS_CONFIG, `OFS_CMD: bresp_next = `RESP_OKAY;
         default: bresp_next = `RESP_SLVERR;
      endcase
   end
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
         awaddr_reg <= 4'h0;
         wdata_reg <= 32'h00000000;
         have_aw_reg <= 1'b0;
         have_w_reg <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !have_aw_reg && s_axi_awvalid && !s_axi_awready;
         s_axi_wready <= !have_w_reg && s_axi_wvalid && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_reg <= s_axi_awaddr;
            have_aw_reg <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_reg <= s_axi_wdata;
            have_w_reg <= 1'b1;
         end
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= bresp_next;
            have_aw_reg <= 1'b0;
            have_w_reg <= 1'b0;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- bench/watchdog_chk.sv ----
// Purpose: port checker for watchdog_timer
// Assumes: one clock, async active-low reset
// Notes: bound to every watchdog_timer instance
`timescale 1ns/1ps
module watchdog_chk
(
   input logic clock,
   input logic arst_n,
   input logic [3:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [3:0] s_axi_araddr,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0] s_axi_rresp,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic watchdog_reset,
   input logic wake_up,
   input logic low_power_rc_oscillator_en
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence aw_taken;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_reset_one_cycle: assert property (watchdog_reset |=> !watchdog_reset)
      else $error("reset pulse too long");
   a_wake_one_cycle: assert property (wake_up |=> !wake_up)
      else $error("wake pulse too long");
   a_wake_not_reset: assert property (!(wake_up && watchdog_reset))
      else $error("reset during low power");
   a_reset_needs_osc: assert property (watchdog_reset |-> $past(low_power_rc_oscillator_en))
      else $error("reset with oscillator off");
   a_wake_needs_osc: assert property (wake_up |-> $past(low_power_rc_oscillator_en))
      else $error("wake with oscillator off");
   a_write_answer: assert property (aw_taken |-> ##[1:4] s_axi_bvalid)
      else $error("write response missing");
   a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read data missing");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
endmodule
bind watchdog_timer watchdog_chk chk (.*);

// ---- bench/tb.sv ----
// Purpose: self-checking bench for watchdog_timer
// Assumes: 25 MHz clock, AXI4-Lite master tasks
// Notes: shortest period keeps the run near 72k cycles
`timescale 1ns/1ps
module tb;
   localparam int P = 782 * 32;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_data;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, watchdog_reset, wake_up, low_power_rc_oscillator_en;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, ev, wr_resp;
   int n_errors = 0, samples_checked = 0, n, t;
   watchdog_timer dut (.*);
   always #20 clock = ~clock;
   // ****************************************
   // Bus and check tasks
   // ****************************************
   task chk(input string nm, input [31:0] seen, input [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      wr_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [3:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
         @(posedge clock);
      while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do
         @(posedge clock);
      while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Watches up to lim cycles for a wake or reset pulse
   task run(input int lim);
      n = 0;
      ev = 2'b00;
      while (ev === 2'b00 && n < lim)
      begin
         @(posedge clock);
         n++;
         ev = {wake_up, watchdog_reset};
      end
   endtask
   task cmd(input [31:0] d, input int lim);
      fork
         wr(4'h8, d);
         run(lim);
      join
   endtask
   task test_done;
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clock);
      n_errors++;
      test_done;
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      t = $urandom(32'h47ba8a18);
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      rd(4'h4);
      chk("config", rd_data, 32'hcf);
      rd(4'h0);
      chk("reset_ctl", rd_data, 32'h0);
      chk("osc_fixed", low_power_rc_oscillator_en, 1);
      rd(4'h2);
      chk("unmapped", rd_resp, 2'b10);
      wr(4'hc, $urandom);
      chk("wr_unmapped", wr_resp, 2'b10);
      wr(4'h4, 32'hc0);
      cmd(32'h1, P + 800);
      chk("expire", ev, 2'b01);
      chk("period", n > P - 800 && n <= P + 8, 1);
      rd(4'h0);
      chk("flag", rd_data[4], 1);
      wr(4'h0, $urandom & 32'hffffffc3);
      chk("wr_okay", wr_resp, 2'b00);
      rd(4'h0);
      chk("flag_clr", rd_data[4], 0);
      cmd(32'h2, P + 800);
      chk("wake", ev, 2'b10);
      chk("wake_time", n > P - 800 && n <= P + 8, 1);
      rd(4'h0);
      chk("sleep_flag", rd_data[3], 1);
      wr(4'h0, 32'h0);
      wr(4'h4, 32'h80);
      cmd(32'h1, 20);
      chk("early_clear", ev, 2'b01);
      cmd(32'h10, 20);
      chk("clk_switch", ev, 2'b00);
      run(19600 + $urandom % 4000);
      chk("no_expire", ev, 2'b00);
      cmd(32'h1, 20);
      chk("late_clear", ev, 2'b00);
      wr(4'h4, 32'h40);
      wr(4'h0, 32'h0);
      repeat (3) @(posedge clock);
      chk("osc_off", low_power_rc_oscillator_en, 0);
      rd(4'hc);
      chk("running", rd_data[0], 0);
      wr(4'h0, 32'h20);
      repeat (3) @(posedge clock);
      chk("osc_sw", low_power_rc_oscillator_en, 1);
      wr(4'h0, 32'h0);
      wr(4'h4, 32'hc0);
      repeat (3) @(posedge clock);
      chk("osc_fix", low_power_rc_oscillator_en, 1);
      test_done;
   end
endmodule
